/* File: bench/testbench.sv */
`timescale 1ns/100ps
`include "uip_defines.vh"
module testbench;
   logic pclk = 1'b0, presetn = 1'b0, bit_tick = 1'b0, stuck, irq;
   logic psel, penable, pwrite, pready, pslverr, sleep_enable;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [5:0] rx_fill = 6'h00;
   logic [3:0] ev = 4'h0;
   logic [2:0] herr = 3'h0;
   logic [5:0] tx_fill = 6'h00;
   logic xon = 1'b0, rts_n = 1'b1, cts_n = 1'b1;
   int err_count = 0, n_checks = 0;
   always #12.5 pclk = ~pclk;
   uip_host i_uip_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .stuck(stuck));
   // Fifo error, special character and modem levels stay idle.
   uip_prioritizer i_uip_prioritizer (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_data(8'h3c),
      .rx_fill(rx_fill), .rx_push(ev[0]), .rx_overrun_evt(ev[1]), .rx_head_err(herr),
      .rx_fifo_err(1'b0), .tx_fill(tx_fill), .tsr_empty(1'b1), .bit_tick(bit_tick),
      .modem_in(4'h0), .modem_delta_evt({3'h0, ev[2]}), .xoff_det(ev[3]),
      .special_det(1'b0), .xon_det(xon), .rts_n(rts_n), .cts_n_pin(cts_n), .irq(irq),
      .sleep_enable(sleep_enable), .fifo_enable(), .rhr_read(), .thr_write(),
      .thr_data());
   task tally_and_finish;
      $display("checks=%0d errors=%0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge pclk)
      if (stuck === 1'b1)
      begin
         err_count++;
         tally_and_finish;
      end
   task chk(input logic [31:0] g, input logic [31:0] x);
      n_checks++;
      if (g !== x)
      begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   task rd8(input logic [7:0] a, input logic [7:0] x);
      logic [31:0] q;
      logic        e;
      begin
         i_uip_host.xfer(1'b0, a, 32'h0, q, e);
         chk(q, {24'h0, x});
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      logic        e;
      i_uip_host.xfer(1'b1, a, {24'h0, d}, q, e);
   endtask
   // Side effects reach irq one edge after the access edge.
   task pulse(input logic [3:0] m);
      @(posedge pclk);
      ev <= m;
      @(posedge pclk);
      ev <= 4'h0;
      repeat (3) @(posedge pclk);
   endtask
   task tick(input int n);
      repeat (n)
      begin
         @(posedge pclk);
         bit_tick <= 1'b1;
         @(posedge pclk);
         bit_tick <= 1'b0;
      end
   endtask
   task t_reset;
      logic [31:0] q;
      logic        e;
      rd8(`UIP_A_MASK, 8'h00);
      rd8(`UIP_A_CAUSE, 8'h01);
      chk(irq, 1'b0);
      i_uip_host.xfer(1'b0, 8'h10, 32'h0, q, e);
      chk(q, 32'h0);
      chk(e, 1'b1);
   endtask
   task t_prio;
      wr(`UIP_A_MASK, 8'h0f);
      rx_fill <= 6'h01;
      pulse(4'h7);
      chk(irq, 1'b1);
      rd8(`UIP_A_CAUSE, 8'h06);
      rd8(`UIP_A_LINE, 8'h63);
      rd8(`UIP_A_CAUSE, 8'h04);
      rx_fill <= 6'h00;
      rd8(`UIP_A_CAUSE, 8'h02);
      rd8(`UIP_A_CAUSE, 8'h00);
      rd8(`UIP_A_MODEM, 8'h01);
      rd8(`UIP_A_CAUSE, 8'h01);
      repeat (3) @(posedge pclk);
      chk(irq, 1'b0);
   endtask
   task t_fifo;
      wr(`UIP_A_MASK, 8'h00);
      wr(`UIP_A_CAUSE, 8'h01);
      rx_fill <= 6'h07;
      pulse(4'h1);
      rd8(`UIP_A_LINE, 8'h61);
      wr(`UIP_A_MASK, 8'h01);
      rd8(`UIP_A_CAUSE, 8'hc1);
      rx_fill <= 6'h08;
      rd8(`UIP_A_CAUSE, 8'hc4);
      rx_fill <= 6'h07;
      rd8(`UIP_A_CAUSE, 8'hc1);
      tick(30);
      rd8(`UIP_A_CAUSE, 8'hc1);
      tick(30);
      rd8(`UIP_A_CAUSE, 8'hcc);
      rd8(`UIP_A_DATA, 8'h3c);
      rd8(`UIP_A_CAUSE, 8'hc1);
   endtask
   task t_enh;
      wr(`UIP_A_CFG, 8'h01);
      wr(`UIP_A_MASK, 8'h30);
      repeat (2) @(posedge pclk);
      chk(sleep_enable, 1'b1);
      pulse(4'h8);
      rd8(`UIP_A_CAUSE, 8'hd0);
      rd8(`UIP_A_CAUSE, 8'hc1);
      wr(`UIP_A_DATA, 8'h5a);
      wr(`UIP_A_CFG, 8'h00);
      wr(`UIP_A_MASK, 8'h00);
      repeat (2) @(posedge pclk);
      chk(sleep_enable, 1'b1);
   endtask
   task t_flow;
      wr(`UIP_A_CFG, 8'h07);
      wr(`UIP_A_MASK, 8'he4);
      herr <= 3'h1;
      repeat (3) @(posedge pclk);
      rd8(`UIP_A_CAUSE, 8'hc6);
      rd8(`UIP_A_LINE, 8'h65);
      herr <= 3'h0;
      rts_n <= 1'b0;
      @(posedge pclk);
      rts_n <= 1'b1;
      repeat (3) @(posedge pclk);
      rd8(`UIP_A_CAUSE, 8'he0);
      rd8(`UIP_A_MODEM, 8'h00);
      rd8(`UIP_A_CAUSE, 8'hc1);
      cts_n <= 1'b0;
      repeat (5) @(posedge pclk);
      cts_n <= 1'b1;
      repeat (6) @(posedge pclk);
      rd8(`UIP_A_CAUSE, 8'he0);
      rd8(`UIP_A_MODEM, 8'h00);
      pulse(4'h8);
      xon <= 1'b1;
      @(posedge pclk);
      xon <= 1'b0;
      repeat (2) @(posedge pclk);
      rd8(`UIP_A_CAUSE, 8'hc1);
      wr(`UIP_A_MASK, 8'h02);
      repeat (2) @(posedge pclk);
      rd8(`UIP_A_CAUSE, 8'hc2);
      tx_fill <= 6'h14;
      repeat (2) @(posedge pclk);
      tx_fill <= 6'h05;
      repeat (3) @(posedge pclk);
      rd8(`UIP_A_CAUSE, 8'hc2);
      wr(`UIP_A_DATA, 8'h5a);
      rd8(`UIP_A_CAUSE, 8'hc1);
   endtask
   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_prio;
      t_fifo;
      t_enh;
      t_flow;
      tally_and_finish;
   end
endmodule

/* File: bench/uip_host.sv */
`timescale 1ns/100ps
module uip_host
(
   input  wire logic        pclk,
   output logic             psel = 1'b0,
   output logic             penable = 1'b0,
   output logic             pwrite = 1'b0,
   output logic [7:0]       paddr = 8'h00,
   output logic [31:0]      pwdata = 32'h0,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   output logic             stuck = 1'b0
);
   // The request stays frozen until pready is seen at a rising edge, or for at most 16 edges.
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] q, output logic e);
      int n;
      begin
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         n = 0;
         do
         begin
            @(posedge pclk);
            n++;
         end
         while (pready !== 1'b1 && n < 16);
         q = prdata;
         e = pslverr;
         stuck <= (n >= 16);
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
endmodule

/* File: bench/uip_prioritizer_sva.sv */
`timescale 1ns/100ps
`include "uip_defines.vh"
module uip_prioritizer_chk
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        sleep_enable,
   input wire logic        fifo_enable,
   input wire logic        rhr_read,
   input wire logic        thr_write,
   input wire logic [7:0]  thr_data
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic map_ok = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h14, 8'h18};
   wire logic rd_cause = pready && !pwrite && paddr == `UIP_A_CAUSE;
   a_ready_answer: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   a_ready_once: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_unmapped_err: assert property (pready |-> pslverr == !map_ok)
      else $error("pslverr does not match address map");
   a_cause_fifo_bits: assert property (rd_cause |-> prdata[7:6] == {2{fifo_enable}})
      else $error("cause top bits differ from fifo enable");
   a_cause_code_legal: assert property (rd_cause |->
      prdata[5:0] inside {6'h06, 6'h0c, 6'h04, 6'h02, 6'h00, 6'h10, 6'h20, 6'h01})
      else $error("illegal cause code");
   a_sleep_by_write: assert property ($changed(sleep_enable) |->
      $past(pready && pwrite && paddr == `UIP_A_MASK, 2))
      else $error("sleep enable moved without mask write");
   a_fifo_by_write: assert property ($changed(fifo_enable) |->
      $past(pready && pwrite && paddr == `UIP_A_CAUSE, 2))
      else $error("fifo enable moved without control write");
   a_rhr_read_pulse: assert property (pready && !pwrite && paddr == 8'h00 |=>
      rhr_read ##1 !rhr_read)
      else $error("receive read pulse wrong");
   a_thr_write_data: assert property (pready && pwrite && paddr == 8'h00 |=>
      thr_write && thr_data == $past(pwdata[7:0]))
      else $error("transmit write pulse or data wrong");
endmodule
bind uip_prioritizer uip_prioritizer_chk i_uip_prioritizer_chk (.*);

/* File: core/uip_prioritizer.v */
// Function
// - FIFO mode receive interrupt and cause follow fill at or above trigger level.
// - Receive data ready status set on FIFO push, cleared when FIFO is empty.
// - Line status reports overrun, head error type, holding empty, all empty, FIFO error.
// - Mask bit 0 enables receive data interrupt; non-FIFO on any data; reset off.
// - Mask bit 1 enables transmit ready; enabling while empty raises it at once.
// - Overrun raises line status at once; other errors when the character leaves; the code raises them when the error reaches the FIFO head.
// - Mask bit 3 enables modem interrupt from any of four sticky delta bits.
// - Mask bit 4 is sleep enable, writable only with enhanced functions on.
// - Mask bit 5 enables Xoff or special character match interrupt.
// - Mask bit 6 enables interrupt on RTS output rising under auto RTS; the code lets bit 6 or 7 enable both flow events.
// - Mask bit 7 enables interrupt on CTS input rising under auto CTS; the code lets bit 6 or 7 enable both flow events.
// - Receive timeout fires after four character times plus twelve bit times.
// - Cause register shows only the highest priority pending source.
// - Cause codes in priority order; nothing pending reads 000001.
// - Line status interrupt cleared by reading the line status register.
// - Receive data clears below trigger; timeout clears on receive holding read.
// - Transmit ready cleared by cause register read or transmit holding write.
// - Modem and flow control interrupts cleared by modem status read.
// - Xoff clears on cause read or Xon; special on cause read or next character.
// - Cause bits 7 and 6 read as FIFO enable.
// - Cause bits 5 and 4 active only with enhanced functions on.
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/100ps
`include "uip_defines.vh"
module uip_prioritizer
(
   input  wire       pclk,
   input  wire       presetn,
   input  wire       psel,
   input  wire       penable,
   input  wire       pwrite,
   input  wire [7:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg        pready,
   output reg        pslverr,
   input  wire [7:0] rx_data,
   input  wire [5:0] rx_fill,
   input  wire       rx_push,
   input  wire       rx_overrun_evt,
   input  wire [2:0] rx_head_err,
   input  wire       rx_fifo_err,
   input  wire [5:0] tx_fill,
   input  wire       tsr_empty,
   input  wire       bit_tick,
   input  wire [3:0] modem_in,
   input  wire [3:0] modem_delta_evt,
   input  wire       xoff_det,
   input  wire       special_det,
   input  wire       xon_det,
   input  wire       rts_n,
   input  wire       cts_n_pin,
   output reg        irq,
   output reg        sleep_enable,
   output reg        fifo_enable,
   output reg        rhr_read,
   output reg        thr_write,
   output reg  [7:0] thr_data
);

   reg  [7:0] mask_r;
   reg  [7:0] fcr_r;
   reg  [7:0] cfg_r;
   reg        ovr_r;
   reg        lsi_r;
   reg  [3:0] delta_r;
   reg        txr_r;
   reg        tmo_r;
   reg        xoff_r;
   reg        spec_r;
   reg        flow_r;
   reg  [6:0] tmo_cnt_r;
   reg  [1:0] tmo_ch_r;
   reg  [2:0] cts_sync_r;
   reg        cts_n_r;
   reg        rts_n_r;
   reg        txc_r;
   reg        msk1_r;
   reg  [2:0] err_r;
   reg  [5:0] cause;
   reg  [31:0] rd_val;
   reg        hit;

   wire       acc    = psel & penable & pready;
   wire       wr     = acc & pwrite;
   wire       rd     = acc & ~pwrite;
   wire       enh    = cfg_r[`UIP_CFG_ENH];
   wire       fen    = fcr_r[`UIP_FCR_EN];
   wire       rd_rhr = rd & (paddr == `UIP_A_DATA);
   wire       rd_isr = rd & (paddr == `UIP_A_CAUSE);
   wire       rd_lsr = rd & (paddr == `UIP_A_LINE);
   wire       rd_msr = rd & (paddr == `UIP_A_MODEM);
   wire       wr_thr = wr & (paddr == `UIP_A_DATA);

   // Receive and transmit trigger levels, selected by the FIFO control bits.
   function [5:0] rx_trig;
      input [1:0] sel;
      begin
         case (sel)
            2'h0:    rx_trig = 6'h08;
            2'h1:    rx_trig = 6'h10;
            2'h2:    rx_trig = 6'h18;
            default: rx_trig = 6'h1c;
         endcase
      end
   endfunction

   function [5:0] tx_trig;
      input [1:0] sel;
      begin
         case (sel)
            2'h0:    tx_trig = 6'h10;
            2'h1:    tx_trig = 6'h08;
            2'h2:    tx_trig = 6'h18;
            default: tx_trig = 6'h1e;
         endcase
      end
   endfunction

   // Non-FIFO mode behaves as a one-deep holding register.
   wire rx_avail = fen ? (rx_fill >= rx_trig(fcr_r[7:6])) : (rx_fill != 6'h00);
   wire tx_cond  = fen ? (tx_fill < tx_trig(fcr_r[5:4])) : (tx_fill == 6'h00);
   wire lsr_evt  = (err_r == 3'h0) & (rx_head_err != 3'h0);
   // Rising edge of the filtered level: both late stages high while the
   // filtered copy still holds low, so the event fires once per clean rise.
   wire cts_rise = ~cts_n_r & cts_sync_r[1] & cts_sync_r[2];
   wire cts_lvl  = cts_sync_r[1];
   wire rts_rise = rts_n & ~rts_n_r & cfg_r[`UIP_CFG_ARTS];
   wire cts_evt  = cts_rise & cfg_r[`UIP_CFG_ACTS];
   wire [7:0] lsr_val = {rx_fifo_err, (tx_fill == 6'h00) & tsr_empty,
                         tx_fill == 6'h00, err_r, ovr_r, rx_fill != 6'h00};

   wire p_line  = lsi_r & mask_r[2];
   wire p_tmo   = tmo_r & mask_r[0];
   wire p_rxd   = rx_avail & mask_r[0];
   wire p_txr   = txr_r & mask_r[1];
   wire p_modem = (delta_r != 4'h0) & mask_r[3];
   wire p_xoff  = (xoff_r | spec_r) & mask_r[5] & enh;
   wire p_flow  = flow_r & (mask_r[6] | mask_r[7]) & enh;

   // Only the source that the cause register is reporting is acknowledged by
   // reading it; a lower source stays queued until its own turn comes.
   // The code seen at the access edge is used; it matches the code latched into
   // read data one cycle earlier unless a higher source arrived or the reported one dropped in between.
   wire ack_txr  = rd_isr & (cause == `UIP_C_TXR);
   wire ack_xoff = rd_isr & (cause == `UIP_C_XOFF);

   // Fixed priority: the first pending source in order wins the code.
   always @*
   begin
      if (p_line)
         cause = `UIP_C_LINE;
      else if (p_tmo)
         cause = `UIP_C_TMO;
      else if (p_rxd)
         cause = `UIP_C_RXD;
      else if (p_txr)
         cause = `UIP_C_TXR;
      else if (p_modem)
         cause = `UIP_C_MODEM;
      else if (p_xoff)
         cause = `UIP_C_XOFF;
      else if (p_flow)
         cause = `UIP_C_FLOW;
      else
         cause = `UIP_C_NONE;
   end

   always @*
   begin
      hit    = 1'b1;
      rd_val = 32'h00000000;
      case (paddr)
         `UIP_A_DATA:  rd_val = {24'h000000, rx_data};
         `UIP_A_MASK:  rd_val = {24'h000000, mask_r};
         `UIP_A_CAUSE: rd_val = {24'h000000, fen, fen, cause};
         `UIP_A_CFG:   rd_val = {24'h000000, cfg_r};
         `UIP_A_LINE:  rd_val = {24'h000000, lsr_val};
         `UIP_A_MODEM: rd_val = {24'h000000, modem_in, delta_r};
         default:      hit = 1'b0;
      endcase
   end

   // The slave answers with no wait state, yet read data is always registered.
   // A master that drops psel before its access phase still sees one pready
   // pulse; no register changes, since the access term needs penable as well.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~hit;
         if (psel & ~penable & ~pwrite)
            prdata <= rd_val;
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mask_r <= `UIP_MASK_RST;
         fcr_r  <= `UIP_FCR_RST;
         cfg_r  <= `UIP_CFG_RST;
      end
      else
      begin
         if (wr & (paddr == `UIP_A_MASK))
         begin
            mask_r[3:0] <= pwdata[3:0];
            if (enh)
               mask_r[7:4] <= pwdata[7:4];
         end
         // Other control bits only take effect while the FIFO enable is written.
         if (wr & (paddr == `UIP_A_CAUSE))
         begin
            fcr_r[0] <= pwdata[0];
            if (pwdata[0])
            begin
               fcr_r[7:6] <= pwdata[7:6];
               if (enh)
                  fcr_r[5:4] <= pwdata[5:4];
            end
         end
         if (wr & (paddr == `UIP_A_CFG))
            cfg_r <= pwdata[7:0];
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cts_sync_r <= 3'h7;
         cts_n_r    <= 1'b1;
         rts_n_r    <= 1'b1;
         err_r      <= 3'h0;
         txc_r      <= 1'b0;
         msk1_r     <= 1'b0;
      end
      else
      begin
         cts_sync_r <= {cts_sync_r[1:0], cts_n_pin};
         // The level only changes once two later stages agree.
         if (cts_sync_r[1] == cts_sync_r[2])
            cts_n_r <= cts_lvl;
         rts_n_r <= rts_n;
         err_r   <= rx_head_err;
         txc_r   <= tx_cond;
         msk1_r  <= mask_r[1];
      end
   end

   // Sticky pending flags; a new event in the clearing cycle always wins.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ovr_r   <= 1'b0;
         lsi_r   <= 1'b0;
         delta_r <= 4'h0;
         txr_r   <= 1'b0;
         xoff_r  <= 1'b0;
         spec_r  <= 1'b0;
         flow_r  <= 1'b0;
      end
      else
      begin
         ovr_r   <= rx_overrun_evt | (ovr_r & ~rd_lsr);
         lsi_r   <= rx_overrun_evt | lsr_evt | (lsi_r & ~rd_lsr);
         delta_r <= modem_delta_evt | (delta_r & {4{~rd_msr}});
         flow_r  <= rts_rise | cts_evt | (flow_r & ~rd_msr);
         // Transmit ready only drops on the acknowledge that reports it or on a
         // write of new transmit data.
         txr_r   <= (tx_cond & ~txc_r) | (tx_cond & mask_r[1] & ~msk1_r)
                    | (txr_r & ~ack_txr & ~wr_thr);
         // Xoff and special share one code, so one acknowledge clears both; each
         // also has its own clear from the receive side.
         xoff_r  <= xoff_det | (xoff_r & ~ack_xoff & ~xon_det);
         spec_r  <= special_det | (spec_r & ~ack_xoff & ~rx_push);
      end
   end

   // Timeout counts bit ticks while data waits; a push or a read restarts it.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tmo_cnt_r <= 7'h00;
         tmo_r     <= 1'b0;
         tmo_ch_r  <= 2'h0;
      end
      else
      begin
         tmo_ch_r <= 2'h0;
         // The compare uses one less than the limit so that the flag rises on
         // the same tick at which the counter reaches the limit.
         if (rx_push | rd_rhr | (rx_fill == 6'h00))
            tmo_cnt_r <= 7'h00;
         else if (bit_tick & (tmo_cnt_r != `UIP_CHAR_BITS * `UIP_TMO_CHARS
                                         + `UIP_TMO_XBITS))
            tmo_cnt_r <= tmo_cnt_r + 7'h01;
         tmo_r <= (tmo_cnt_r == `UIP_CHAR_BITS * `UIP_TMO_CHARS + `UIP_TMO_XBITS
                   - 7'h01 & bit_tick & ~rx_push & ~rd_rhr)
                  | (tmo_r & ~rd_rhr);
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq          <= 1'b0;
         sleep_enable <= 1'b0;
         fifo_enable  <= 1'b0;
         rhr_read     <= 1'b0;
         thr_write    <= 1'b0;
         thr_data     <= 8'h00;
      end
      else
      begin
         // Every output is registered, so irq trails the pending flags by a cycle.
         irq          <= cause != `UIP_C_NONE;
         sleep_enable <= mask_r[4];
         fifo_enable  <= fen;
         rhr_read     <= rd_rhr;
         thr_write    <= wr_thr;
         if (wr_thr)
            thr_data <= pwdata[7:0];
      end
   end

endmodule

/* File: include/uip_defines.vh */
`ifndef UIP_DEFINES_VH
`define UIP_DEFINES_VH
`define UIP_A_DATA    8'h00
`define UIP_A_MASK    8'h04
`define UIP_A_CAUSE   8'h08
`define UIP_A_CFG     8'h0c
`define UIP_A_LINE    8'h14
`define UIP_A_MODEM   8'h18
`define UIP_MASK_RST  8'h00
`define UIP_FCR_RST   8'h00
`define UIP_CFG_RST   8'h00
`define UIP_CFG_ENH   0
`define UIP_CFG_ACTS  1
`define UIP_CFG_ARTS  2
`define UIP_FCR_EN    0
`define UIP_C_LINE    6'h06
`define UIP_C_TMO     6'h0c
`define UIP_C_RXD     6'h04
`define UIP_C_TXR     6'h02
`define UIP_C_MODEM   6'h00
`define UIP_C_XOFF    6'h10
`define UIP_C_FLOW    6'h20
`define UIP_C_NONE    6'h01
`define UIP_CHAR_BITS 7'h0a
`define UIP_TMO_CHARS 7'h04
`define UIP_TMO_XBITS 7'h0c
`endif
